// ### verilog/sild_pkg.sv
// Constants shared by the serial-in latched driver and its host end.
// Assumes both ends run on clk_sys at 200 MHz and meet in sild_link_if.
// Notes on behaviour
// [RQ1] Shift clock rise captures serial data input
// [RQ2] Each rise advances stages toward serial output
// [RQ3] Host holds shift clock high 100 ns
// [RQ4] Host waits 300 ns before raising load
// [RQ5] Host holds load high 100 ns
// [RQ6] Latches transparent while load is high
// [RQ7] Load tied high needs blanking during shifting
// [RQ8] Blanking high drives every output low
// [RQ9] Blanking never alters latch contents
// [RQ10] Blanking low: outputs follow their latches
// [RQ11] Ten stages, ten latches, ten outputs
// [RQ12] Last stage drives serial output for cascading
// [RQ13] Load low: latches hold their values
package sild_pkg;
   // Stage count and system clock
   localparam int WIDTH        = 10;
   localparam int SYS_PERIOD_PS = 5000;
   // Host-side minimum times, in ns as given
   localparam int CLK_HIGH_NS  = 100;
   localparam int CLK_TO_LD_NS = 300;
   localparam int LD_HIGH_NS   = 100;
   // Minimum times round up to whole cycles
   localparam int CLK_HIGH_CYC  = (CLK_HIGH_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
   localparam int CLK_TO_LD_CYC = (CLK_TO_LD_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
   localparam int LD_HIGH_CYC   = (LD_HIGH_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
   // Counter width covering the longest count
   localparam int CNT_W = 7;
   localparam logic [WIDTH-1:0] ZERO_WORD = 10'h000;
endpackage : sild_pkg

// ### verilog/sild_link_if.sv
// Pins between host controller and the latched driver.
// Assumes both ends share clk_sys only for their own logic; the pins are async.
`timescale 1ns/10ps
`default_nettype none
interface sild_link_if;
   logic shift_clk;  // Shift clock from host
   logic ser_in;     // Serial data into driver
   logic load;       // Latch load, high transparent
   logic blank;      // Blanking, high forces outputs low
   logic ser_out;    // Cascade output of last stage
   modport host (output shift_clk, ser_in, load, blank, input ser_out);
   modport dev  (input shift_clk, ser_in, load, blank, output ser_out);
endinterface : sild_link_if
`default_nettype wire

// ### verilog/sild_host.sv
// Host end: shifts a word out and pulses the load line.
// Assumes a user strobes send_req for one cycle with data in send_word.
`timescale 1ns/10ps
`default_nettype none
module sild_host (
   // Clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      nrst,
   // User side
   input  wire logic                      send_req,
   input  wire logic [sild_pkg::WIDTH-1:0] send_word,
   input  wire logic                      blank_req,
   output logic                           busy,
   // Link
   sild_link_if.host                      link
);
   typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_GAP, S_LOAD} sild_st_type;

   sild_st_type                   st_r;
   logic [sild_pkg::WIDTH-1:0]    word_r;
   logic [3:0]                    bits_r;
   logic [sild_pkg::CNT_W-1:0]    cnt_r;
   logic                          sclk_r;
   logic                          sdat_r;
   logic                          load_r;
   logic                          blank_r;

   // Sequencer: MSB first so bit 9 lands in the last stage
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_r   <= S_IDLE;
         word_r <= sild_pkg::ZERO_WORD;
         bits_r <= 4'h0;
         cnt_r  <= '0;
         sclk_r <= 1'b0;
         sdat_r <= 1'b0;
         load_r <= 1'b0;
      end else begin
         case (st_r)
            S_IDLE: begin
               if (send_req) begin
                  word_r <= send_word;
                  bits_r <= 4'h0;
                  cnt_r  <= '0;
                  st_r   <= S_LOW;
               end
            end
            S_LOW: begin
               // Low phase lasts one clock-high width; data holds through low and high phases
               sdat_r <= word_r[sild_pkg::WIDTH-1];
               cnt_r  <= cnt_r + 1'b1;
               if (cnt_r == sild_pkg::CNT_W'(sild_pkg::CLK_HIGH_CYC - 1)) begin
                  cnt_r  <= '0;
                  sclk_r <= 1'b1;
                  st_r   <= S_HIGH;
               end
            end
            S_HIGH: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == sild_pkg::CNT_W'(sild_pkg::CLK_HIGH_CYC - 1)) begin // RQ3
                  cnt_r  <= '0;
                  sclk_r <= 1'b0;
                  word_r <= {word_r[sild_pkg::WIDTH-2:0], 1'b0};
                  bits_r <= bits_r + 4'h1;
                  st_r   <= (bits_r == 4'(sild_pkg::WIDTH - 1)) ? S_GAP : S_LOW;
               end
            end
            S_GAP: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == sild_pkg::CNT_W'(sild_pkg::CLK_TO_LD_CYC - 1)) begin // RQ4
                  cnt_r  <= '0;
                  load_r <= 1'b1;
                  st_r   <= S_LOAD;
               end
            end
            S_LOAD: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == sild_pkg::CNT_W'(sild_pkg::LD_HIGH_CYC - 1)) begin // RQ5
                  cnt_r  <= '0;
                  load_r <= 1'b0;
                  st_r   <= S_IDLE;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // Blanking is a plain level; load is never tied high, so shifting stays hidden
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) blank_r <= 1'b1;
      else       blank_r <= blank_req; // RQ7
   end

   assign busy           = (st_r != S_IDLE);
   assign link.shift_clk = sclk_r;
   assign link.ser_in    = sdat_r;
   assign link.load      = load_r;
   assign link.blank     = blank_r;
endmodule : sild_host
`default_nettype wire

// ### verilog/sild_dev.sv
// Driver end: ten-stage shift register, latches and blanked outputs.
// Assumes link pins are asynchronous to clk_sys; each is synchronised here.
`timescale 1ns/10ps
`default_nettype none
module sild_dev (
   // Clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      nrst,
   // Link
   sild_link_if.dev                       link,
   // Parallel outputs
   output logic [sild_pkg::WIDTH-1:0]     drv_out,
   output logic [sild_pkg::WIDTH-1:0]     latch_val
);
   logic [1:0]                  sclk_s;
   logic [1:0]                  sdat_s;
   logic [1:0]                  load_s;
   logic [1:0]                  blank_s;
   logic                        sclk_d_r;
   logic [sild_pkg::WIDTH-1:0]  shreg_r;
   logic [sild_pkg::WIDTH-1:0]  latch_r;
   logic [sild_pkg::WIDTH-1:0]  out_r;
   logic                        rise;

   // Two-flop synchronisers on every pin
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sclk_s  <= 2'h0;
         sdat_s  <= 2'h0;
         load_s  <= 2'h0;
         blank_s <= 2'h3;
      end else begin
         sclk_s  <= {sclk_s[0], link.shift_clk};
         sdat_s  <= {sdat_s[0], link.ser_in};
         load_s  <= {load_s[0], link.load};
         blank_s <= {blank_s[0], link.blank};
      end
   end

   // Edge finder reads only the second stage
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) sclk_d_r <= 1'b0;
      else       sclk_d_r <= sclk_s[1];
   end
   assign rise = sclk_s[1] & ~sclk_d_r;

   // Data delayed as much as clock, so setup at the pins is kept
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) shreg_r <= sild_pkg::ZERO_WORD;
      else if (rise) shreg_r <= {shreg_r[sild_pkg::WIDTH-2:0], sdat_s[1]}; // RQ1 RQ2 RQ11
   end

   // Transparent while load high, hold otherwise; blank not involved
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) latch_r <= sild_pkg::ZERO_WORD;
      else if (load_s[1]) latch_r <= shreg_r; // RQ6 RQ13 RQ9
   end

   // Outputs registered; blank forces all low
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) out_r <= sild_pkg::ZERO_WORD;
      else out_r <= blank_s[1] ? sild_pkg::ZERO_WORD : latch_r; // RQ8 RQ10
   end

   assign drv_out      = out_r;
   assign latch_val    = latch_r;
   assign link.ser_out = shreg_r[sild_pkg::WIDTH-1]; // RQ12
endmodule : sild_dev
`default_nettype wire

// ### testbench/sild_properties.sv
// Checker for link pins and outputs of the driver end.
// Assumes pins reach the driver through two sync flops.
`timescale 1ns/10ps
`default_nettype none
module sild_checker (
   // Clock and reset
   input wire logic                       clk_sys,
   input wire logic                       nrst,
   // Link and outputs
   input wire logic                       shift_clk,
   input wire logic                       load,
   input wire logic                       blank,
   input wire logic                       ser_out,
   input wire logic [sild_pkg::WIDTH-1:0] drv_out,
   input wire logic [sild_pkg::WIDTH-1:0] latch_val
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Run lengths of host pins; saturate so a long idle cannot wrap
   logic [7:0]                            clk_hi_r;
   logic [7:0]                            clk_lo_r;
   logic [7:0]                            ld_hi_r;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         clk_hi_r <= 8'h00;
         clk_lo_r <= 8'h00;
         ld_hi_r  <= 8'h00;
      end else begin
         clk_hi_r <= !shift_clk ? 8'h00 : (clk_hi_r == 8'hFF) ? 8'hFF : clk_hi_r + 8'h01;
         clk_lo_r <= shift_clk ? 8'h00 : (clk_lo_r == 8'hFF) ? 8'hFF : clk_lo_r + 8'h01;
         ld_hi_r  <= !load ? 8'h00 : (ld_hi_r == 8'hFF) ? 8'hFF : ld_hi_r + 8'h01;
      end
   end
   // Host timing, measured in whole clk_sys cycles at the pins
   chk_clk_width: assert property ($fell(shift_clk) |-> clk_hi_r >= sild_pkg::CLK_HIGH_CYC)
      else $error("shift clock high too short");
   chk_clk_to_load: assert property ($rose(load) |-> clk_lo_r >= sild_pkg::CLK_TO_LD_CYC)
      else $error("load raised too soon after clock");
   chk_load_width: assert property ($fell(load) |-> ld_hi_r >= sild_pkg::LD_HIGH_CYC)
      else $error("load high too short");
   // Windows allow for sync latency
   chk_blank_holds: assert property (blank[*6] |-> drv_out == '0)
      else $error("outputs live under blanking");
   chk_blank_rise: assert property ($rose(blank) |-> ##[2:6] drv_out == '0)
      else $error("blanking slow");
   chk_out_follow: assert property ((!blank)[*6] ##0 $stable(latch_val)[*2]
      |-> drv_out == latch_val)
      else $error("output differs from latch");
   chk_latch_hold: assert property ((!load)[*6] |-> $stable(latch_val))
      else $error("latch moved without load");
   chk_blank_keeps: assert property ((!load)[*6] ##0 $changed(blank)
      |=> $stable(latch_val)[*3])
      else $error("blanking altered latch");
   chk_latch_ser: assert property (load[*8] |-> latch_val[9] == ser_out)
      else $error("last latch differs from serial out");
   chk_ser_hold: assert property ((!shift_clk)[*6] |-> $stable(ser_out))
      else $error("serial out moved without clock");
   // Pin to latch is two sync flops plus the latch flop: exactly three cycles
   chk_latch_cause: assert property ($changed(latch_val)
      |-> $past(load, 3))
      else $error("latch changed with load low");
endmodule : sild_checker
`default_nettype wire

// ### testbench/sild_tb.sv
// Bench: host end feeds driver end; an integer model checks each word.
// Assumes package, interface, both ends and checker compiled before.
`timescale 1ns/10ps
`default_nettype none
module sild_tb;
   logic                       clk_sys;
   logic                       nrst;
   logic                       send_req;
   logic                       blank_req;
   logic                       busy;
   logic [sild_pkg::WIDTH-1:0] send_word;
   logic [sild_pkg::WIDTH-1:0] w;
   logic [sild_pkg::WIDTH-1:0] drv_out;
   logic [sild_pkg::WIDTH-1:0] latch_val;
   int                         error_cnt;
   int                         tests_run;
   int                         seed;
   int                         sh;
   sild_link_if link ();
   sild_host i_sild_host (.clk_sys(clk_sys), .nrst(nrst), .send_req(send_req),
      .send_word(send_word), .blank_req(blank_req), .busy(busy), .link(link));
   sild_dev i_sild_dev (.clk_sys(clk_sys), .nrst(nrst), .link(link),
      .drv_out(drv_out), .latch_val(latch_val));
   sild_checker i_sild_checker (.clk_sys(clk_sys), .nrst(nrst), .shift_clk(link.shift_clk),
      .load(link.load), .blank(link.blank), .ser_out(link.ser_out),
      .drv_out(drv_out), .latch_val(latch_val));
   // Free-running 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   function automatic int xs(input int x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask : chk
   task automatic chk_bit(input string name, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
         error_cnt++;
      end
   endtask : chk_bit
   // Cycle counts are bench integers, never unknown
   task automatic chk_cyc(input string name, input int exp, input int got);
      tests_run++;
      if (got != exp) begin
         $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
         error_cnt++;
      end
   endtask : chk_cyc
   // Bounded wait on busy; then let sync stages settle
   task automatic send(input logic [9:0] v);
      int n;
      send_word <= v;
      send_req <= 1'b1;
      @(posedge clk_sys);
      send_req <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (busy !== 1'b0 && n < 3000);
      if (n >= 3000) begin
         error_cnt++;
         tally_and_finish();
      end else begin
         // Ten low and high phases, the gap, then the load pulse
         chk_cyc("busy cycles", 2 * sild_pkg::WIDTH * sild_pkg::CLK_HIGH_CYC
            + sild_pkg::CLK_TO_LD_CYC + sild_pkg::LD_HIGH_CYC, n);
         repeat (8) @(posedge clk_sys);
      end
   endtask : send
   // Main sequence: boundary words first, then random ones
   initial begin
      nrst = 1'b0;
      send_req = 1'b0;
      blank_req = 1'b0;
      send_word = '0;
      error_cnt = 0;
      tests_run = 0;
      seed = 33;
      sh = 0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         w = (k == 0) ? 10'h3FF : (k == 1) ? 10'h000 : seed[9:0];
         send(w);
         for (int i = 9; i >= 0; i--) sh = ((sh << 1) | w[i]) & 10'h3FF;
         chk("latch", sh[9:0], latch_val);
         chk_bit("serial", sh[9], link.ser_out);
         chk("output", sh[9:0], drv_out);
         blank_req <= 1'b1;
         repeat (8) @(posedge clk_sys);
         chk("blanked", 10'h000, drv_out);
         chk("held", sh[9:0], latch_val);
         blank_req <= 1'b0;
         repeat (8) @(posedge clk_sys);
         chk("restored", sh[9:0], drv_out);
      end
      tally_and_finish();
   end
endmodule : sild_tb
`default_nettype wire
